/* src/audio_routing_pkg.sv */
// Register map and field layout for the audio port signal routing block
package audio_routing_pkg;

	// ----------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [7:0] IDX_SECONDARY_PIN_SELECT = 8'h1F;
	localparam logic [7:0] IDX_PORT_CLOCK_SELECT    = 8'h20;
	localparam logic [7:0] IDX_PIN_OUTPUT_ROUTING   = 8'h21;
	localparam logic [7:0] IDX_CONTROL_PORT_MISC    = 8'h22;
	localparam logic [7:0] IDX_PIN_DIRECTION        = 8'h23;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_ROUTING = 8'h00;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	// Secondary pin select
	localparam int SPS_BCLK_LSB  = 5;
	localparam int SPS_WCLK_LSB  = 3;
	localparam int SPS_ADCWC_LSB = 1;
	localparam int SPS_DIN_BIT   = 0;
	localparam logic [7:0] SPS_WMASK = 8'h7F;
	// Port clock select
	localparam int PCS_BCLK_BIT  = 3;
	localparam int PCS_WCLK_BIT  = 2;
	localparam int PCS_ADCWC_BIT = 1;
	localparam int PCS_DIN_BIT   = 0;
	localparam logic [7:0] PCS_WMASK = 8'h0F;
	// Pin output routing
	localparam int POR_BCLK_BIT   = 7;
	localparam int POR_SBCLK_BIT  = 6;
	localparam int POR_WCLK_LSB   = 4;
	localparam int POR_SWCLK_LSB  = 2;
	localparam int POR_DOUT_BIT   = 1;
	localparam int POR_SDOUT_BIT  = 0;
	localparam logic [7:0] POR_WMASK = 8'hFF;
	// Control port misc
	localparam int CPM_GCALL_BIT = 5;
	localparam logic [7:0] CPM_WMASK = 8'h20;
	// Pin direction
	localparam int DIR_BCLK_BIT = 3;
	localparam int DIR_WCLK_BIT = 2;
	localparam logic [7:0] DIR_WMASK = 8'h0C;

	// ----------------------------------------------------------------
	// Mux codes
	// ----------------------------------------------------------------
	localparam logic [1:0] SEL_GPIO = 2'h0;
	localparam logic [1:0] SEL_SCLK = 2'h1;
	localparam logic [1:0] SEL_MISO = 2'h2;
	localparam logic [1:0] SEL_DOUT = 2'h3;

	localparam logic [1:0] WOUT_A   = 2'h0;
	localparam logic [1:0] WOUT_B   = 2'h1;
	localparam logic [1:0] WOUT_C   = 2'h2;

endpackage

/* src/audio_port_signal_routing.sv */
// Audio serial port pin and clock routing with a classic Wishbone register slave
// Notes on behaviour
// - Secondary bit clock pin chosen by two bits
// - Secondary word clock pin chosen likewise
// - ADC word clock pin select, code 11 banned
// - Secondary data in from GPIO or SCLK
// - Bit clock: primary or secondary source
// - Word clock: primary or secondary source
// - ADC word clock: DAC or secondary
// - Audio data in: primary or secondary
// - Bit clock pin out: generated or secondary
// - Secondary bit clock out: pin or generated
// - Word clock out select, code 11 banned
// - Secondary word clock out select, 11 banned
// - Data out pin: interface or loopback
// - Secondary data out: loopback or interface
// - General call accepted only when enabled
// - Bit clock pin direction bit
// - Word clock pin direction bit
`timescale 1ns/1ns

module audio_port_signal_routing
	import audio_routing_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Wishbone slave
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [9:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic [31:0]      dat_o,
	output logic             ack_o,
	output logic             err_o,
	// Multi-function pins (asynchronous inputs)
	input  wire logic        gpio_pin_i,
	input  wire logic        sclk_pin_i,
	input  wire logic        miso_pin_i,
	input  wire logic        dout_pin_i,
	input  wire logic        bclk_pin_i,
	input  wire logic        wclk_pin_i,
	input  wire logic        din_pin_i,
	// Internal clocks and data, same clock domain
	input  wire logic        gen_bclk_i,
	input  wire logic        playback_frame_sync_i,
	input  wire logic        record_frame_sync_i,
	input  wire logic        serial_dout_i,
	input  wire logic        gcall_seen_i,
	// Pin drivers; enables are low while driving
	output logic             bclk_pin_o,
	output logic             bclk_pin_oe_n_o,
	output logic             wclk_pin_o,
	output logic             wclk_pin_oe_n_o,
	output logic             dout_pin_o,
	output logic             sec_bclk_o,
	output logic             sec_wclk_o,
	output logic             sec_dout_o,
	// Toward the serial interface
	output logic             iface_bclk_o,
	output logic             iface_wclk_o,
	output logic             adc_wclk_o,
	output logic             iface_din_o,
	output logic             gcall_accept_o
);

	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------
	localparam int NPIN = 7;
	logic [NPIN-1:0] pin_meta;
	logic [NPIN-1:0] pin_sync;
	wire  [NPIN-1:0] pin_raw = {din_pin_i, wclk_pin_i, bclk_pin_i, dout_pin_i,
	                            miso_pin_i, sclk_pin_i, gpio_pin_i};

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_meta <= '0;
			pin_sync <= '0;
		end else begin
			pin_meta <= pin_raw;
			pin_sync <= pin_meta;
		end
	end

	wire s_gpio = pin_sync[0];
	wire s_sclk = pin_sync[1];
	wire s_miso = pin_sync[2];
	wire s_dout = pin_sync[3];
	wire s_bclk = pin_sync[4];
	wire s_wclk = pin_sync[5];
	wire s_din  = pin_sync[6];

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [7:0] secondary_pin_select;
	logic [7:0] port_clock_select;
	logic [7:0] pin_output_routing;
	logic [7:0] control_port_misc;
	logic [7:0] pin_direction;

	// Four-way pin pick, used by five multiplexers
	function automatic logic pick4(input logic [1:0] code, input logic a,
	                               input logic b, input logic c, input logic d);
		case (code)
			2'h0:    pick4 = a;
			2'h1:    pick4 = b;
			2'h2:    pick4 = c;
			default: pick4 = d;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// Wishbone slave
	// ----------------------------------------------------------------
	wire       bus_req  = cyc_i & stb_i & ~ack_o & ~err_o;
	wire [7:0] reg_idx  = adr_i[9:2];
	wire       hit_sps  = (reg_idx == IDX_SECONDARY_PIN_SELECT);
	wire       hit_pcs  = (reg_idx == IDX_PORT_CLOCK_SELECT);
	wire       hit_por  = (reg_idx == IDX_PIN_OUTPUT_ROUTING);
	wire       hit_cpm  = (reg_idx == IDX_CONTROL_PORT_MISC);
	wire       hit_dir  = (reg_idx == IDX_PIN_DIRECTION);
	wire       mapped   = hit_sps | hit_pcs | hit_por | hit_cpm | hit_dir;
	wire       wr_low   = bus_req & we_i & mapped & sel_i[0];

	wire       wr_sps   = wr_low & hit_sps;
	wire       wr_pcs   = wr_low & hit_pcs;
	wire       wr_por   = wr_low & hit_por;
	wire       wr_cpm   = wr_low & hit_cpm;
	wire       wr_dir   = wr_low & hit_dir;
	wire       rd_ans   = bus_req & ~we_i & mapped;

	// Reserved bits are masked so they always read zero
	wire [7:0] wdata    = dat_i[7:0];
	// Bit 4 reports a general call seen; bit 5 keeps the enable
	wire [7:0] cpm_read = {control_port_misc[7:5], gcall_seen_i, control_port_misc[3:0]};
	wire [7:0] rd_byte  = hit_sps ? secondary_pin_select :
	                      hit_pcs ? port_clock_select :
	                      hit_por ? pin_output_routing :
	                      hit_cpm ? cpm_read :
	                      hit_dir ? pin_direction : 8'h00;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			secondary_pin_select <= RST_ROUTING;
		end else if (wr_sps) begin
			secondary_pin_select <= wdata & SPS_WMASK;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			port_clock_select <= RST_ROUTING;
		end else if (wr_pcs) begin
			port_clock_select <= wdata & PCS_WMASK;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_output_routing <= RST_ROUTING;
		end else if (wr_por) begin
			pin_output_routing <= wdata & POR_WMASK;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			control_port_misc <= RST_ROUTING;
		end else if (wr_cpm) begin
			control_port_misc <= wdata & CPM_WMASK;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_direction <= RST_ROUTING;
		end else if (wr_dir) begin
			pin_direction <= wdata & DIR_WMASK;
		end
	end

	// One wait-free answer, then ack drops for a cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			err_o <= 1'b0;
		end else begin
			ack_o <= bus_req & mapped;
			err_o <= bus_req & ~mapped;
		end
	end

	// Read data stands only in the answer cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_o <= 32'h0000_0000;
		end else begin
			dat_o <= rd_ans ? {24'h00_0000, rd_byte} : 32'h0000_0000;
		end
	end

	// ----------------------------------------------------------------
	// Secondary pin selection
	// ----------------------------------------------------------------
	wire [1:0] sps_bclk  = secondary_pin_select[SPS_BCLK_LSB +: 2];
	wire [1:0] sps_wclk  = secondary_pin_select[SPS_WCLK_LSB +: 2];
	wire [1:0] sps_adcwc = secondary_pin_select[SPS_ADCWC_LSB +: 2];

	wire sec_bclk_in  = pick4(sps_bclk, s_gpio, s_sclk, s_miso, s_dout);
	wire sec_wclk_in  = pick4(sps_wclk, s_gpio, s_sclk, s_miso, s_dout);
	// banned code falls back to GPIO
	wire sec_adcwc_in = pick4(sps_adcwc, s_gpio, s_sclk, s_miso, s_gpio);
	wire sec_din_in   = secondary_pin_select[SPS_DIN_BIT] ? s_sclk : s_gpio;

	// ----------------------------------------------------------------
	// Interface source selection
	// ----------------------------------------------------------------
	// bit clock source
	wire next_iface_bclk = port_clock_select[PCS_BCLK_BIT] ? sec_bclk_in : s_bclk;
	wire next_iface_wclk = port_clock_select[PCS_WCLK_BIT] ? sec_wclk_in : s_wclk;
	// ADC word clock follows DAC unless split
	wire next_adc_wclk   = port_clock_select[PCS_ADCWC_BIT] ? sec_adcwc_in : next_iface_wclk;
	wire next_iface_din  = port_clock_select[PCS_DIN_BIT] ? sec_din_in : s_din;

	// ----------------------------------------------------------------
	// Pin output selection
	// ----------------------------------------------------------------
	wire [1:0] por_wclk  = pin_output_routing[POR_WCLK_LSB +: 2];
	wire [1:0] por_swclk = pin_output_routing[POR_SWCLK_LSB +: 2];

	wire next_bclk_pin  = pin_output_routing[POR_BCLK_BIT] ? sec_bclk_in : gen_bclk_i;
	wire next_sec_bclk  = pin_output_routing[POR_SBCLK_BIT] ? gen_bclk_i : s_bclk;
	// word clock pin, banned code as 00
	wire next_wclk_pin  = pick4(por_wclk, playback_frame_sync_i, record_frame_sync_i,
	                            sec_wclk_in, playback_frame_sync_i);
	// secondary word clock, banned code as 00
	wire next_sec_wclk  = pick4(por_swclk, s_wclk, playback_frame_sync_i,
	                            record_frame_sync_i, s_wclk);
	wire next_dout_pin  = pin_output_routing[POR_DOUT_BIT] ? sec_din_in : serial_dout_i;
	wire next_sec_dout  = pin_output_routing[POR_SDOUT_BIT] ? serial_dout_i : s_din;

	// ----------------------------------------------------------------
	// Output flops
	// ----------------------------------------------------------------
	// One extra cycle of latency, but glitch-free clocks toward the core
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			iface_bclk_o    <= 1'b0;
			iface_wclk_o    <= 1'b0;
			adc_wclk_o      <= 1'b0;
			iface_din_o     <= 1'b0;
		end else begin
			iface_bclk_o    <= next_iface_bclk;
			iface_wclk_o    <= next_iface_wclk;
			adc_wclk_o      <= next_adc_wclk;
			iface_din_o     <= next_iface_din;
		end
	end

	// Pin levels registered likewise, so no mux glitch reaches a pin
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bclk_pin_o      <= 1'b0;
			wclk_pin_o      <= 1'b0;
			sec_bclk_o      <= 1'b0;
			sec_wclk_o      <= 1'b0;
			dout_pin_o      <= 1'b0;
			sec_dout_o      <= 1'b0;
		end else begin
			bclk_pin_o      <= next_bclk_pin;
			wclk_pin_o      <= next_wclk_pin;
			sec_bclk_o      <= next_sec_bclk;
			sec_wclk_o      <= next_sec_wclk;
			dout_pin_o      <= next_dout_pin;
			sec_dout_o      <= next_sec_dout;
		end
	end

	// ----------------------------------------------------------------
	// Pin drive and control port
	// ----------------------------------------------------------------
	// bit clock pin driven when set
	assign bclk_pin_oe_n_o = ~pin_direction[DIR_BCLK_BIT];
	// word clock pin driven when set
	assign wclk_pin_oe_n_o = ~pin_direction[DIR_WCLK_BIT];
	assign gcall_accept_o  = control_port_misc[CPM_GCALL_BIT];

endmodule // audio_port_signal_routing

/* testbench/audio_routing_asserts.sv */
// Port checks for the audio routing block
`timescale 1ns/1ns
module audio_routing_asserts
	import audio_routing_pkg::*;
(
	input wire logic        clk_i, rst_i, cyc_i, stb_i, we_i,
	input wire logic [9:0]  adr_i,
	input wire logic [3:0]  sel_i,
	input wire logic [31:0] dat_i, dat_o,
	input wire logic        ack_o, err_o, gen_bclk_i, record_frame_sync_i, serial_dout_i,
	input wire logic        wclk_pin_o, dout_pin_o, sec_bclk_o, sec_dout_o,
	input wire logic        bclk_pin_oe_n_o, wclk_pin_oe_n_o, gcall_accept_o
);
	logic [7:0] sh;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// Shadow of output routing, taken at the acked write
	always_ff @(posedge clk_i) begin
		if (rst_i)
			sh <= 8'h00;
		else if (ack_o && we_i && sel_i[0] && adr_i[9:2] == IDX_PIN_OUTPUT_ROUTING)
			sh <= dat_i[7:0];
	end
	ack_pulse_a: assert property (ack_o |=> !ack_o) else $error("ack too long");
	bus_answer_a: assert property (cyc_i && stb_i && !ack_o && !err_o |=> ack_o != err_o)
		else $error("no answer");
	idle_data_a: assert property (!ack_o |-> dat_o == 32'h0) else $error("stray data");
	reset_state_a: assert property ($fell(rst_i) |->
		bclk_pin_oe_n_o && wclk_pin_oe_n_o && !gcall_accept_o) else $error("bad reset");
	dout_path_a: assert property (!$past(rst_i) && !sh[1] && !$past(sh[1])
		|-> dout_pin_o == $past(serial_dout_i)) else $error("dout pin");
	sdout_path_a: assert property (!$past(rst_i) && sh[0] && $past(sh[0])
		|-> sec_dout_o == $past(serial_dout_i)) else $error("sec dout");
	rec_sync_a: assert property (!$past(rst_i) && sh[5:4] == 2'h1
		&& $past(sh[5:4]) == 2'h1 |-> wclk_pin_o == $past(record_frame_sync_i))
		else $error("wclk pin");
	gen_bclk_a: assert property (!$past(rst_i) && sh[6] && $past(sh[6])
		|-> sec_bclk_o == $past(gen_bclk_i)) else $error("sec bclk");
	cover property (ack_o && !we_i);
	cover property (err_o);
	cover property (sh[5:4] == 2'h1);
endmodule // audio_routing_asserts

bind audio_port_signal_routing audio_routing_asserts u_audio_routing_asserts (.*);

/* testbench/audio_far_end.sv */
// Far-side audio device driving the multi-function pins
`timescale 1ns/1ns
module audio_far_end (
	input  wire logic       run_i,
	input  wire logic [6:0] lvl_i,
	output logic [6:0]      pins_o
);
	logic lclk = 1'b0;
	// Link clock stands still at low while run_i is low
	always #40 lclk = run_i ? ~lclk : 1'b0;
	assign pins_o = run_i ? {lvl_i[6], lclk, lvl_i[4:0]} : lvl_i;
endmodule // audio_far_end

/* testbench/tb.sv */
// Self-checking bench for the audio routing block
`timescale 1ns/1ns
module tb;
	import audio_routing_pkg::*;
	logic        clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, run = 1'b0;
	logic [9:0]  adr_i = '0;
	wire  [9:0]  outs;
	logic [3:0]  sel_i = '0;
	logic [31:0] dat_i = '0, dat_o;
	logic        ack_o, err_o, bclk_pin_oe_n_o, wclk_pin_oe_n_o, gcall_accept_o;
	logic [4:0]  inl = '0;
	logic [6:0]  lvl = '0, pins;
	int          n_fail = 0, total_checks = 0;
	always #5 clk_i = ~clk_i;
	audio_far_end u_audio_far_end (.run_i(run), .lvl_i(lvl), .pins_o(pins));
	audio_port_signal_routing u_audio_port_signal_routing (.*, .gpio_pin_i(pins[6]),
		.sclk_pin_i(pins[5]), .miso_pin_i(pins[4]), .dout_pin_i(pins[3]), .bclk_pin_i(pins[2]),
		.wclk_pin_i(pins[1]), .din_pin_i(pins[0]), .gen_bclk_i(inl[4]),
		.playback_frame_sync_i(inl[3]), .record_frame_sync_i(inl[2]), .serial_dout_i(inl[1]),
		.gcall_seen_i(inl[0]), .bclk_pin_o(outs[5]), .wclk_pin_o(outs[4]),
		.dout_pin_o(outs[3]), .sec_bclk_o(outs[2]), .sec_wclk_o(outs[1]), .sec_dout_o(outs[0]),
		.iface_bclk_o(outs[9]), .iface_wclk_o(outs[8]), .adc_wclk_o(outs[7]),
		.iface_din_o(outs[6]));
	task automatic wb(input logic w, input logic [7:0] a, d, output logic [7:0] q,
		output logic e);
		@(posedge clk_i);
		{cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} <= {2'b11, w, a, 2'b00, 4'h1, 24'h0, d};
		do @(posedge clk_i); while (!(ack_o | err_o));
		{e, q} = {err_o, dat_o[7:0]};
		{cyc_i, stb_i} <= 2'b00;
	endtask
	task automatic chk(input logic [31:0] got, exp);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	function automatic logic [9:0] model(logic [7:0] s, p, r, logic [6:0] n, logic [4:0] i);
		logic [3:0] m, wv, sv;
		logic       iw;
		m = {n[3], n[4], n[5], n[6]};
		iw = p[2] ? m[s[4:3]] : n[1];
		wv = {i[3], m[s[4:3]], i[2], i[3]};
		sv = {n[1], i[2], i[3], n[1]};
		// Record word clock follows the playback one unless split off
		return {p[3] ? m[s[6:5]] : n[2], iw, p[1] ? (s[2:1] == 2'h3 ? n[6] : m[s[2:1]]) : iw,
			p[0] ? (s[0] ? n[5] : n[6]) : n[0],
			r[7] ? m[s[6:5]] : i[4], wv[r[5:4]], r[1] ? (s[0] ? n[5] : n[6]) : i[1],
			r[6] ? i[4] : n[2], sv[r[3:2]], r[0] ? i[1] : n[0]};
	endfunction
	task automatic t_regs();
		logic [7:0] q, msk [5];
		logic e;
		msk = '{8'h7F, 8'h0F, 8'hFF, 8'h20, 8'h0C};
		for (int j = 0; j < 5; j++) begin
			wb(0, IDX_SECONDARY_PIN_SELECT + 8'(j), 8'h00, q, e);
			chk({e, q}, 9'h000);
			wb(1, IDX_SECONDARY_PIN_SELECT + 8'(j), msk[j], q, e);
			wb(0, IDX_SECONDARY_PIN_SELECT + 8'(j), 8'h00, q, e);
			chk({e, q}, {1'b0, msk[j]});
		end
		chk({bclk_pin_oe_n_o, wclk_pin_oe_n_o, gcall_accept_o}, 3'b001);
		inl <= 5'h01;
		wb(0, IDX_CONTROL_PORT_MISC, 8'h00, q, e);
		chk({e, q}, 9'h030);
		inl <= 5'h00;
		wb(0, 8'h24, 8'h00, q, e);
		chk({e, q}, 9'h100);
		for (int j = 0; j < 5; j++)
			wb(1, IDX_SECONDARY_PIN_SELECT + 8'(j), 8'h00, q, e);
		chk({bclk_pin_oe_n_o, wclk_pin_oe_n_o, gcall_accept_o}, 3'b110);
		$display("register test done");
	endtask
	task automatic t_route();
		logic [7:0] q, s, p, r;
		logic [9:0] x;
		logic e;
		for (int m = 0; m < 8; m++) begin
			s = {1'b0, m[1:0], m[1:0], m[1:0], m[0]};
			p = m[2] ? 8'h0F : 8'h00;
			r = {m[0], m[1], m[1:0], m[1:0], m[0], m[1]};
			wb(1, IDX_SECONDARY_PIN_SELECT, s, q, e);
			wb(1, IDX_PORT_CLOCK_SELECT, p, q, e);
			wb(1, IDX_PIN_OUTPUT_ROUTING, r, q, e);
			for (int k = 0; k < 12; k++) begin
				lvl <= (k < 7) ? 7'h01 << k : 7'h00;
				inl <= (k < 7) ? 5'h00 : 5'h01 << (k - 7);
				repeat (5) @(posedge clk_i);
				x = model(s, p, r, lvl, inl);
				chk(outs[9:6], x[9:6]);
				chk(outs[5:0], x[5:0]);
			end
		end
		$display("routing test done");
	endtask
	task automatic t_link();
		logic [7:0] q;
		logic e, pv;
		int n;
		wb(1, IDX_SECONDARY_PIN_SELECT, 8'h20, q, e);
		wb(1, IDX_PORT_CLOCK_SELECT, 8'h08, q, e);
		run <= 1'b1;
		{pv, n} = '0;
		repeat (400) begin
			@(posedge clk_i);
			n += int'(outs[9] && !pv);
			pv = outs[9];
		end
		run <= 1'b0;
		chk(n >= 49 && n <= 51, 1);
		$display("link test done");
	endtask
	task automatic give_verdict();
		$display("checks %0d fails %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		t_regs();
		t_route();
		t_link();
		give_verdict();
	end
	// Whole run needs about 1000 cycles
	initial begin
		#200000;
		n_fail++;
		give_verdict();
	end
endmodule // tb
